// *** shared/flash_cmd_pkg.sv ***
package flash_cmd_pkg;

	// ==========================================================
	// instruction codes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;

	// ==========================================================
	// status register layout
	localparam int BIT_BUSY = 0;
	localparam int BIT_WRITE_ENABLE_LATCH = 1;
	localparam int BIT_BLOCK_PROTECT_LO = 2;
	localparam int BIT_BLOCK_PROTECT_HI = 3;
	localparam int BIT_TOP_BOTTOM_SELECT = 5;
	localparam int BIT_STATUS_LOCK = 7;
	localparam logic [7:0] STATUS_WRITABLE_MASK = 8'hac;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ==========================================================
	// frame lengths, in link clocks
	localparam logic [4:0] OPCODE_LAST = 5'h07;
	localparam logic [4:0] SINGLE_ADDR_LAST = 5'h17;
	localparam logic [4:0] DUAL_ADDR_LAST = 5'h0b;
	localparam logic [4:0] MODE_LAST = 5'h03;
	localparam logic [4:0] DUMMY_LAST = 5'h07;
	localparam logic [4:0] STATUS_DATA_LAST = 5'h07;
	localparam logic [4:0] MODE_RESET_LAST = 5'h0f;
	localparam logic [1:0] CONT_ENABLE_PAIR = 2'h2;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int STATUS_WRITE_NS = 10000;
	localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// types
	typedef struct packed {
		logic statusLockBit;
		logic reserved6;
		logic topBottomSelect;
		logic reserved4;
		logic blockProtectHi;
		logic blockProtectLo;
		logic writeEnableLatch;
		logic busy;
	} flash_status_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0] data;
	} mem_load_t;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_SET_LATCH,
		CMD_CLEAR_LATCH,
		CMD_VOLATILE_ENABLE,
		CMD_STATUS_WRITE
	} frame_cmd_t;

	typedef struct packed {
		frame_cmd_t cmd;
		logic [7:0] data;
	} frame_result_t;

	typedef enum {
		PH_OPCODE,
		PH_ADDR,
		PH_MODE,
		PH_DUMMY,
		PH_DATA,
		PH_STATUS,
		PH_STATUS_DATA,
		PH_IGNORE
	} link_phase_t;

endpackage : flash_cmd_pkg

// *** core/serial_flash_status_and_read_commands.sv ***
`timescale 1ns/1ns
`default_nettype none

// How it works
// - opcode 06h sets the write-enable latch
// - status write refused unless latch or volatile enable set; host sets latch first
// - opcode 50h arms only the next status write as volatile, latch untouched
// - opcode 04h clears the write-enable latch
// - latch clears at reset and when a non-volatile status write completes
// - opcode 04h also cancels a pending volatile enable
// - after 05h the status byte shifts out msb first on falling edges
// - status read works while busy and repeats until chip select rises
// - 01h takes one data byte, accepted with latch or volatile enable
// - status write changes only bits 7, 5, 3 and 2
// - status write executes only if chip select rises right after the first data byte
// - non-volatile write runs timed with busy set, then clears busy and latch
// - lock bit set and protect pin low rejects status writes
// - volatile status write updates bits at once, busy stays zero
// - 03h plus 24-bit address streams byte msb first on falling edges
// - address increments after every byte, streaming until chip select rises
// - data reads issued while busy are ignored
// - 0Bh adds eight dummy clocks before data
// - 3Bh outputs two bits per clock after address and dummy clocks
// - BBh takes address and mode bits two per clock, line one high
// - mode pair 10 makes next frame an opcode-less dual address read
// - any other mode pair returns to full opcodes; low mode bits ignored
// - dual output puts even bits on line zero, odd on line one
// - sixteen clocks of ones leave continuous read mode
// - while busy everything but status read and the sixteen-ones mode reset is ignored
module serial_flash_status_and_read_commands
	import flash_cmd_pkg::*;
#(
	parameter int MEM_BYTES = 256,
	parameter int STATUS_WRITE_COUNT = STATUS_WRITE_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic chipSelectN,
	input wire logic writeProtectN,
	input wire logic dualLineZeroIn,
	output logic dualLineZeroOut,
	output logic dualLineZeroOeN,
	input wire logic dualLineOneIn,
	output logic dualLineOneOut,
	output logic dualLineOneOeN,
	input wire logic memLoadValid,
	input wire mem_load_t memLoad,
	output flash_status_t flashStatusRegister
);

	localparam int MEM_AW = $clog2(MEM_BYTES);
	localparam int TIMER_W = $clog2(STATUS_WRITE_COUNT + 1);

	// ==========================================================
	// system clock side
	flash_status_t status;
	flash_status_t mergedFrame;
	flash_status_t mergedPending;
	logic volatileEnable;
	logic [TIMER_W-1:0] writeTimer;
	logic [7:0] pendingData;
	logic [1:0] csSync;
	logic csPrev;
	logic [1:0] wpSync;
	logic frameEnd;
	logic seenSeq;
	logic freshResult;
	logic statusWriteAllowed;
	frame_result_t frameResult;
	logic [7:0] memArray [MEM_BYTES];

	// ==========================================================
	// link clock side
	link_phase_t phase;
	logic [4:0] cnt;
	logic [23:0] shiftIn;
	logic [23:0] readAddr;
	logic [2:0] beatIdx;
	logic dualAddr;
	logic dualData;
	logic fastRead;
	logic contMode;
	logic [4:0] onesCount;
	logic onesRun;
	logic modeReset;
	logic modeDone;
	logic [7:0] continuousModeBits;
	logic [7:0] opByte;
	logic [7:0] memByte;
	flash_status_t statusMeta;
	flash_status_t statusLink;
	logic resultSeq;

	assign flashStatusRegister = status;

	// ==========================================================
	// pin synchronisers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			csSync <= 2'h3;
			csPrev <= 1'b1;
			wpSync <= 2'h3;
			seenSeq <= 1'b0;
		end
		else
		begin
			csSync <= {csSync[0], chipSelectN};
			csPrev <= csSync[1];
			wpSync <= {wpSync[0], writeProtectN};
			if (frameEnd)
			begin
				seenSeq <= resultSeq;
			end
		end
	end

	assign frameEnd = csSync[1] & ~csPrev;
	// only an outcome from a clocked frame acts, never a replay
	assign freshResult = resultSeq ^ seenSeq;
	assign statusWriteAllowed = (status.writeEnableLatch | volatileEnable)
		& ~(status.statusLockBit & ~wpSync[1]);
	assign mergedFrame = (status & ~STATUS_WRITABLE_MASK)
		| (frameResult.data & STATUS_WRITABLE_MASK);
	assign mergedPending = (status & ~STATUS_WRITABLE_MASK)
		| (pendingData & STATUS_WRITABLE_MASK);

	// ==========================================================
	// status register and command execution
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			status <= STATUS_RESET;
			volatileEnable <= 1'b0;
			writeTimer <= '0;
			pendingData <= 8'h00;
		end
		else if (status.busy)
		begin
			// everything but status read is dropped here
			writeTimer <= writeTimer - 1'b1;
			if (writeTimer == TIMER_W'(1))
			begin
				status <= mergedPending;
				status.busy <= 1'b0;
				status.writeEnableLatch <= 1'b0;
			end
		end
		else if (frameEnd && freshResult)
		begin
			unique case (frameResult.cmd)
				CMD_SET_LATCH: status.writeEnableLatch <= 1'b1;
				CMD_CLEAR_LATCH:
				begin
					status.writeEnableLatch <= 1'b0;
					volatileEnable <= 1'b0;
				end
				CMD_VOLATILE_ENABLE: volatileEnable <= 1'b1;
				CMD_STATUS_WRITE:
				begin
					volatileEnable <= 1'b0;
					if (statusWriteAllowed && volatileEnable)
					begin
						status <= mergedFrame;
					end
					else if (statusWriteAllowed)
					begin
						status.busy <= 1'b1;
						writeTimer <= TIMER_W'(STATUS_WRITE_COUNT);
						pendingData <= frameResult.data;
					end
				end
				CMD_NONE:
				begin
				end
			endcase
		end
	end

	// ==========================================================
	// array storage, preloaded from the system side
	always_ff @(posedge clk)
	begin
		if (memLoadValid)
		begin
			memArray[memLoad.addr[MEM_AW-1:0]] <= memLoad.data;
		end
	end

	assign memByte = memArray[readAddr[MEM_AW-1:0]];

	// ==========================================================
	// status bits into the link domain, two stages each
	always_ff @(posedge sck)
	begin
		statusMeta <= status;
		statusLink <= statusMeta;
	end

	// ==========================================================
	// frame decoding on rising link edges
	assign opByte = {shiftIn[6:0], dualLineZeroIn};
	assign modeDone = (phase == PH_MODE) && (cnt == MODE_LAST);
	assign continuousModeBits = {shiftIn[5:0], dualLineOneIn, dualLineZeroIn};

	always_ff @(posedge sck or posedge chipSelectN)
	begin
		if (chipSelectN)
		begin
			phase <= PH_OPCODE;
			cnt <= 5'h00;
			shiftIn <= 24'h000000;
			readAddr <= 24'h000000;
			beatIdx <= 3'h0;
			dualAddr <= 1'b0;
			dualData <= 1'b0;
			fastRead <= 1'b0;
		end
		else
		begin
			unique case (phase)
				PH_OPCODE:
				begin
					if (cnt == 5'h00 && contMode)
					begin
						// opcode skipped, first address pair
						shiftIn <= {shiftIn[21:0], dualLineOneIn, dualLineZeroIn};
						cnt <= 5'h01;
						phase <= statusLink.busy ? PH_IGNORE : PH_ADDR;
						dualAddr <= 1'b1;
						dualData <= 1'b1;
						fastRead <= 1'b1;
					end
					else if (cnt == OPCODE_LAST)
					begin
						cnt <= 5'h00;
						shiftIn <= {shiftIn[22:0], dualLineZeroIn};
						dualAddr <= (opByte == OP_DUAL_IO_READ);
						dualData <= (opByte == OP_DUAL_IO_READ) || (opByte == OP_DUAL_OUT_READ);
						fastRead <= (opByte != OP_READ);
						if (opByte == OP_READ_STATUS)
						begin
							phase <= PH_STATUS;
						end
						else if (opByte == OP_WRITE_STATUS)
						begin
							phase <= PH_STATUS_DATA;
						end
						else if (opByte == OP_READ || opByte == OP_FAST_READ
							|| opByte == OP_DUAL_OUT_READ || opByte == OP_DUAL_IO_READ)
						begin
							phase <= statusLink.busy ? PH_IGNORE : PH_ADDR;
						end
						else
						begin
							phase <= PH_IGNORE;
						end
					end
					else
					begin
						cnt <= cnt + 5'h01;
						shiftIn <= {shiftIn[22:0], dualLineZeroIn};
					end
				end
				PH_ADDR:
				begin
					cnt <= cnt + 5'h01;
					if (dualAddr)
					begin
						shiftIn <= {shiftIn[21:0], dualLineOneIn, dualLineZeroIn};
					end
					else
					begin
						shiftIn <= {shiftIn[22:0], dualLineZeroIn};
					end
					if (dualAddr && cnt == DUAL_ADDR_LAST)
					begin
						readAddr <= {shiftIn[21:0], dualLineOneIn, dualLineZeroIn};
						cnt <= 5'h00;
						phase <= PH_MODE;
					end
					else if (!dualAddr && cnt == SINGLE_ADDR_LAST)
					begin
						readAddr <= {shiftIn[22:0], dualLineZeroIn};
						cnt <= 5'h00;
						phase <= fastRead ? PH_DUMMY : PH_DATA;
					end
				end
				PH_MODE:
				begin
					cnt <= cnt + 5'h01;
					shiftIn <= {shiftIn[21:0], dualLineOneIn, dualLineZeroIn};
					if (cnt == MODE_LAST)
					begin
						cnt <= 5'h00;
						phase <= PH_DATA;
					end
				end
				PH_DUMMY:
				begin
					cnt <= cnt + 5'h01;
					if (cnt == DUMMY_LAST)
					begin
						cnt <= 5'h00;
						phase <= PH_DATA;
					end
				end
				PH_DATA:
				begin
					if (beatIdx == (dualData ? 3'h3 : 3'h7))
					begin
						beatIdx <= 3'h0;
						readAddr <= readAddr + 24'h000001;
					end
					else
					begin
						beatIdx <= beatIdx + 3'h1;
					end
				end
				PH_STATUS: beatIdx <= beatIdx + 3'h1;
				PH_STATUS_DATA:
				begin
					shiftIn <= {shiftIn[22:0], dualLineZeroIn};
					if (cnt != 5'h1f)
					begin
						cnt <= cnt + 5'h01;
					end
				end
				PH_IGNORE:
				begin
				end
			endcase
		end
	end

	// ==========================================================
	// frame outcome, read by the system side after chip select rises
	always_ff @(posedge sck or posedge rst)
	begin
		if (rst)
		begin
			frameResult <= '{cmd: CMD_NONE, data: 8'h00};
			resultSeq <= 1'b0;
		end
		else
		begin
			frameResult.cmd <= CMD_NONE;
			if (phase == PH_OPCODE && cnt == OPCODE_LAST && !chipSelectN)
			begin
				if (opByte == OP_WRITE_ENABLE)
				begin
					frameResult.cmd <= CMD_SET_LATCH;
					resultSeq <= ~resultSeq;
				end
				else if (opByte == OP_WRITE_DISABLE)
				begin
					frameResult.cmd <= CMD_CLEAR_LATCH;
					resultSeq <= ~resultSeq;
				end
				else if (opByte == OP_VOLATILE_ENABLE)
				begin
					frameResult.cmd <= CMD_VOLATILE_ENABLE;
					resultSeq <= ~resultSeq;
				end
			end
			else if (phase == PH_STATUS_DATA && cnt == STATUS_DATA_LAST)
			begin
				frameResult.cmd <= CMD_STATUS_WRITE;
				frameResult.data <= opByte;
				resultSeq <= ~resultSeq;
			end
		end
	end

	// ==========================================================
	// continuous read mode
	always_ff @(posedge sck or posedge chipSelectN)
	begin
		if (chipSelectN)
		begin
			onesCount <= 5'h00;
			onesRun <= 1'b1;
		end
		else if (onesRun && dualLineZeroIn)
		begin
			onesCount <= (onesCount == MODE_RESET_LAST) ? onesCount : onesCount + 5'h01;
		end
		else
		begin
			onesRun <= 1'b0;
		end
	end

	assign modeReset = onesRun && dualLineZeroIn && (onesCount == MODE_RESET_LAST);

	always_ff @(posedge sck or posedge rst)
	begin
		if (rst)
		begin
			contMode <= 1'b0;
		end
		else if (modeReset && !chipSelectN)
		begin
			contMode <= 1'b0;
		end
		else if (modeDone && !chipSelectN)
		begin
			contMode <= (continuousModeBits[5:4] == CONT_ENABLE_PAIR);
		end
	end

	// ==========================================================
	// pin drivers on falling link edges
	always_ff @(negedge sck or posedge chipSelectN)
	begin
		if (chipSelectN)
		begin
			dualLineZeroOut <= 1'b0;
			dualLineZeroOeN <= 1'b1;
			dualLineOneOut <= 1'b0;
			dualLineOneOeN <= 1'b1;
		end
		else if (phase == PH_DATA && dualData)
		begin
			dualLineZeroOut <= memByte[{2'h3 - beatIdx[1:0], 1'b0}];
			dualLineOneOut <= memByte[{2'h3 - beatIdx[1:0], 1'b1}];
			dualLineZeroOeN <= 1'b0;
			dualLineOneOeN <= 1'b0;
		end
		else if (phase == PH_DATA)
		begin
			dualLineOneOut <= memByte[3'h7 - beatIdx];
			dualLineOneOeN <= 1'b0;
			dualLineZeroOeN <= 1'b1;
		end
		else if (phase == PH_STATUS)
		begin
			dualLineOneOut <= statusLink[3'h7 - beatIdx];
			dualLineOneOeN <= 1'b0;
			dualLineZeroOeN <= 1'b1;
		end
		else
		begin
			dualLineZeroOeN <= 1'b1;
			dualLineOneOeN <= 1'b1;
		end
	end

endmodule : serial_flash_status_and_read_commands

`default_nettype wire

// *** sim/flash_cmd_chk.sv ***
`timescale 1ns/1ns
`default_nettype none

// =====
// status and pin checks
module flash_cmd_chk
	import flash_cmd_pkg::*;
#(
	parameter int STATUS_WRITE_COUNT = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic chipSelectN,
	input wire logic writeProtectN,
	input wire logic dualLineZeroOeN,
	input wire logic dualLineOneOeN,
	input wire flash_status_t flashStatusRegister
);
	logic busy;
	logic write_enable_latch;
	logic [15:0] busyCnt;
	assign busy = flashStatusRegister.busy;
	assign write_enable_latch = flashStatusRegister.writeEnableLatch;

	// length of the current busy spell
	always_ff @(posedge clk)
	begin
		if (rst || !busy)
			busyCnt <= '0;
		else
			busyCnt <= busyCnt + 16'h0001;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence writeStart;
		$rose(busy);
	endsequence
	sequence writeEnd;
		$fell(busy);
	endsequence

	AST_CLEAN_START: assert property ($fell(rst) |-> flashStatusRegister == STATUS_RESET)
		else $error("status not clear after reset");
	AST_RESERVED_ZERO: assert property (!flashStatusRegister.reserved6 && !flashStatusRegister.reserved4)
		else $error("reserved status bit set");
	AST_WRITE_NEEDS_LATCH: assert property (writeStart |-> $past(write_enable_latch))
		else $error("write cycle without latch");
	AST_WRITE_AFTER_CS: assert property (writeStart |-> chipSelectN && $past(chipSelectN, 2))
		else $error("write cycle before chip select rise");
	AST_WRITE_LOCK: assert property (writeStart |-> !$past(flashStatusRegister.statusLockBit) || $past(writeProtectN, 4))
		else $error("locked status written");
	AST_WRITE_BOUNDED: assert property (writeStart |-> ##[1:1000] writeEnd)
		else $error("write cycle never ends");
	AST_WRITE_END: assert property (writeEnd |-> !write_enable_latch)
		else $error("latch kept after write cycle");
	AST_BUSY_COUNT: assert property (busyCnt <= 16'(STATUS_WRITE_COUNT) + 16'h0008)
		else $error("busy too long");
	AST_BUSY_EXACT: assert property (writeEnd |-> busyCnt == 16'(STATUS_WRITE_COUNT))
		else $error("write cycle length wrong");
	AST_SET_LATCH: assert property ($rose(write_enable_latch) |-> chipSelectN && $past(chipSelectN, 2))
		else $error("latch set inside frame");
	AST_RELEASED: assert property (chipSelectN |-> dualLineZeroOeN && dualLineOneOeN)
		else $error("line driven while deselected");
	AST_ZERO_WITH_ONE: assert property (!dualLineZeroOeN |-> !dualLineOneOeN)
		else $error("line zero driven alone");
endmodule : flash_cmd_chk

bind serial_flash_status_and_read_commands flash_cmd_chk #(
	.STATUS_WRITE_COUNT(STATUS_WRITE_COUNT)
) chk (
	.clk(clk),
	.rst(rst),
	.chipSelectN(chipSelectN),
	.writeProtectN(writeProtectN),
	.dualLineZeroOeN(dualLineZeroOeN),
	.dualLineOneOeN(dualLineOneOeN),
	.flashStatusRegister(flashStatusRegister)
);

`default_nettype wire

// *** sim/spi_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// =====
// host side of the link, mode 0, 32 ns clock
module spi_host_model
(
	output logic sck,
	output logic chipSelectN,
	output logic hostZero,
	output logic hostOne,
	input wire logic wireZero,
	input wire logic wireOne,
	input wire logic oneOeN
);
	initial
	begin
		sck = 1'b0;
		chipSelectN = 1'b1;
		hostZero = 1'b0;
		hostOne = 1'b0;
	end

	// nSingle clocks on line zero, then pairs, then nOut read clocks
	task automatic xfer(input logic [63:0] tx, input int nIn, input int nOut, input int nSingle,
		output logic [63:0] rx, output logic [63:0] rx2, output bit drove);
		rx = '0;
		rx2 = '0;
		drove = 1'b0;
		#3 chipSelectN = 1'b0;
		for (int i = 0; i < nIn + nOut; i++)
		begin
			if (i < nSingle)
			begin
				hostZero = tx[63];
				hostOne = ~hostOne;
				tx = tx << 1;
			end
			else if (i < nIn)
			begin
				{hostOne, hostZero} = tx[63:62];
				tx = tx << 2;
			end
			#16 sck = 1'b1;
			rx = {rx[62:0], wireOne};
			rx2 = {rx2[61:0], wireOne, wireZero};
			drove |= !oneOeN;
			#1;
			if (i >= nIn - 1)
				{hostOne, hostZero} = ~{hostOne, hostZero};
			#15 sck = 1'b0;
		end
		#8 chipSelectN = 1'b1;
		#72;
	endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// *** sim/serial_flash_status_and_read_commands_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end

// =====
// bench top
module serial_flash_status_and_read_commands_tb_top
	import flash_cmd_pkg::*;
;
	logic clk, rst, writeProtectN, memLoadValid;
	mem_load_t memLoad;
	logic sck, chipSelectN, hostZero, hostOne, lineZero, lineOne;
	logic zeroOut, zeroOeN, oneOut, oneOeN;
	flash_status_t status;
	int checks, fail_count;
	logic [63:0] rx, rx2;
	bit drove, sawBusy;

	assign lineZero = zeroOeN ? hostZero : zeroOut;
	assign lineOne = oneOeN ? hostOne : oneOut;

	serial_flash_status_and_read_commands #(.MEM_BYTES(256), .STATUS_WRITE_COUNT(400)) uut (
		.clk(clk), .rst(rst), .sck(sck), .chipSelectN(chipSelectN), .writeProtectN(writeProtectN),
		.dualLineZeroIn(lineZero), .dualLineZeroOut(zeroOut), .dualLineZeroOeN(zeroOeN),
		.dualLineOneIn(lineOne), .dualLineOneOut(oneOut), .dualLineOneOeN(oneOeN),
		.memLoadValid(memLoadValid), .memLoad(memLoad), .flashStatusRegister(status)
	);

	spi_host_model host (
		.sck(sck), .chipSelectN(chipSelectN), .hostZero(hostZero), .hostOne(hostOne),
		.wireZero(lineZero), .wireOne(lineOne), .oneOeN(oneOeN)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
		if (status.busy === 1'b1)
			sawBusy = 1'b1;

	function automatic logic [7:0] pat(input logic [7:0] a);
		return a * 8'h03 + 8'h11;
	endfunction : pat

	task automatic frame(input logic [63:0] tx, input int nIn, input int nOut, input int nSingle);
		host.xfer(tx << (64 - 2 * nIn + nSingle), nIn, nOut, nSingle, rx, rx2, drove);
	endtask : frame

	task automatic waitIdle;
		repeat (600)
			if (status.busy !== 1'b0)
				@(posedge clk);
	endtask : waitIdle

	task automatic t_latch;
		frame(OP_WRITE_ENABLE, 8, 0, 8);
		frame(OP_READ_STATUS, 8, 16, 8);
		`CHECK(rx[15:0], 16'h0202)
		frame(OP_WRITE_DISABLE, 8, 0, 8);
		frame(OP_READ_STATUS, 8, 8, 8);
		`CHECK(rx[7:0], 8'h00)
		$display("latch test done");
	endtask : t_latch

	task automatic t_read;
		frame({OP_READ, 24'h0000fe}, 32, 24, 32);
		`CHECK(rx[23:0], {pat(8'hfe), pat(8'hff), pat(8'h00)})
		frame({OP_FAST_READ, 24'h000010, 8'h5a}, 40, 16, 40);
		`CHECK(rx[15:0], {pat(8'h10), pat(8'h11)})
		frame({OP_DUAL_OUT_READ, 24'h000020, 8'h5a}, 40, 8, 40);
		`CHECK(rx2[15:0], {pat(8'h20), pat(8'h21)})
		$display("read test done");
	endtask : t_read

	task automatic t_dual;
		frame({OP_DUAL_IO_READ, 24'h000030, 8'h20}, 24, 4, 8);
		`CHECK(rx2[7:0], pat(8'h30))
		frame({24'h000040, 8'h0f}, 16, 4, 0);
		`CHECK(rx2[7:0], pat(8'h40))
		frame(OP_READ_STATUS, 8, 8, 8);
		`CHECK(rx[7:0], 8'h00)
		frame({OP_DUAL_IO_READ, 24'h000050, 8'h2f}, 24, 4, 8);
		frame(16'hffff, 16, 0, 16);
		frame(OP_READ_STATUS, 8, 8, 8);
		`CHECK(rx[7:0], 8'h00)
		$display("dual test done");
	endtask : t_dual

	task automatic t_write;
		frame({OP_WRITE_STATUS, 8'hff}, 16, 0, 16);
		`CHECK(status, 8'h00)
		frame(OP_WRITE_ENABLE, 8, 0, 8);
		frame({OP_WRITE_STATUS, 7'h7f}, 15, 0, 15);
		`CHECK(status, 8'h02)
		frame({OP_WRITE_STATUS, 8'hff}, 16, 0, 16);
		`CHECK(status.busy, 1'b1)
		frame({OP_READ, 24'h000000}, 32, 8, 32);
		`CHECK(drove, 1'b0)
		frame(OP_WRITE_DISABLE, 8, 0, 8);
		frame(OP_READ_STATUS, 8, 8, 8);
		`CHECK(rx[1:0], 2'b11)
		frame(OP_WRITE_ENABLE, 8, 0, 8);
		waitIdle;
		frame(64'h0, 0, 0, 0);
		`CHECK(status, 8'hac)
		$display("write test done");
	endtask : t_write

	task automatic t_volatile;
		sawBusy = 1'b0;
		frame(OP_VOLATILE_ENABLE, 8, 0, 8);
		frame({OP_WRITE_STATUS, 8'h84}, 16, 0, 16);
		`CHECK(status, 8'h84)
		`CHECK(sawBusy, 1'b0)
		frame(OP_VOLATILE_ENABLE, 8, 0, 8);
		frame(OP_WRITE_DISABLE, 8, 0, 8);
		frame({OP_WRITE_STATUS, 8'h00}, 16, 0, 16);
		`CHECK(status, 8'h84)
		@(posedge clk);
		#1 writeProtectN = 1'b0;
		frame(OP_WRITE_ENABLE, 8, 0, 8);
		frame({OP_WRITE_STATUS, 8'h00}, 16, 0, 16);
		`CHECK(status[7:2], 6'h21)
		@(posedge clk);
		#1 writeProtectN = 1'b1;
		frame(OP_WRITE_ENABLE, 8, 0, 8);
		frame({OP_WRITE_STATUS, 8'h00}, 16, 0, 16);
		waitIdle;
		`CHECK(status, 8'h00)
		$display("volatile test done");
	endtask : t_volatile

	task automatic conclude;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	initial
	begin
		rst = 1'b1;
		writeProtectN = 1'b1;
		memLoadValid = 1'b0;
		memLoad = '0;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		for (int a = 0; a < 256; a++)
		begin
			@(posedge clk);
			#1 memLoadValid = 1'b1;
			memLoad = {16'h0000, 8'(a), pat(8'(a))};
		end
		@(posedge clk);
		#1 memLoadValid = 1'b0;
		t_latch;
		t_read;
		t_dual;
		t_write;
		t_volatile;
		conclude;
	end

	initial
	begin
		#400000;
		fail_count++;
		conclude;
	end
endmodule : serial_flash_status_and_read_commands_tb_top

`default_nettype wire
